// ---- pkg/adcs_defs.svh ----
// shared constants of the conversion sequencer: addresses, codes, counts
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

// register addresses on the plain register port
`define ADCS_ADDR_W          4
`define ADCS_ADDR_CTRL       4'h0
`define ADCS_ADDR_RESULT     4'h1
`define ADCS_ADDR_INJ_CTRL   4'h2
`define ADCS_ADDR_INJ_RESULT 4'h3
`define ADCS_ADDR_IRQ_STATUS 4'h4
`define ADCS_ADDR_IRQ_MASK   4'h5
`define ADCS_ADDR_PINS       4'h6
`define ADCS_ADDR_FLAGS      4'h7

// data and channel widths
`define ADCS_DATA_W          16
`define ADCS_RES_W           10
`define ADCS_CHAN_W          4
`define ADCS_NCHAN           16

// reset values
`define ADCS_CTRL_RST        16'h0000
`define ADCS_CNT_RST         16'h0000

// mode field bits: bit 0 continuous, bit 1 auto-scan
`define ADCS_MODE_CONT       0
`define ADCS_MODE_SCAN       1
`define ADCS_MODE_SGL_ONCE   2'h0

// conversion clock select codes and lengths in base clock periods
`define ADCS_TCC_CODE_24     2'h0
`define ADCS_TCC_CODE_96     2'h2
`define ADCS_TCC_CODE_48     2'h3
`define ADCS_TCC_24          16'h0018
`define ADCS_TCC_48          16'h0030
`define ADCS_TCC_96          16'h0060

// conversion clocks per conversion phase, mclk cycles per base period
`define ADCS_CONV_PERIODS    10
`define ADCS_BASE_DIV        1

// interrupt status bits
`define ADCS_IRQ_W           3
`define ADCS_IRQ_DONE        0
`define ADCS_IRQ_OVR         1
`define ADCS_IRQ_INJ         2

`endif

// ---- pkg/adcs_pkg.sv ----
// types of the conversion sequencer
`default_nettype none
`include "adcs_defs.svh"
package adcs_pkg;

	// fsm states
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_HOLD} adcs_fsm_t;

	// register port request
	typedef struct packed {
		logic [`ADCS_ADDR_W-1:0] addr;
		logic [`ADCS_DATA_W-1:0] wdata;
		logic                    wr;
		logic                    rd;
	} adcs_bus_t;

	// converter_control_reg layout
	typedef struct packed {
		logic [1:0]              ctc;      // conversion_clock_select
		logic [1:0]              stc;      // sample_clock_select
		logic [1:0]              rsv_hi;
		logic                    ovr_susp;
		logic                    wfr;      // wait_for_read_enable
		logic                    start;
		logic                    rsv_lo;
		logic [1:0]              mode;
		logic [`ADCS_CHAN_W-1:0] chan;
	} adcs_ctrl_t;

	// conversion_result_reg and injection_result_reg layout
	typedef struct packed {
		logic [`ADCS_CHAN_W-1:0] chan;
		logic [1:0]              rsv;
		logic [`ADCS_RES_W-1:0]  val;      // result_value_field
	} adcs_result_t;

	// injection control layout
	typedef struct packed {
		logic [10:0]             rsv;
		logic                    req;
		logic [`ADCS_CHAN_W-1:0] chan;
	} adcs_inj_t;

	// whole state of the sequencer
	typedef struct packed {
		adcs_fsm_t               st;
		adcs_ctrl_t              ctrl;
		logic                    busy;
		logic [`ADCS_CHAN_W-1:0] cur_chan;
		logic [`ADCS_CHAN_W-1:0] mux_chan;
		logic                    inj_active;
		logic                    inj_pend;
		logic [`ADCS_CHAN_W-1:0] inj_chan;
		logic [15:0]             cnt;
		adcs_result_t            res;
		logic                    res_full;
		adcs_result_t            tmp;
		logic                    tmp_full;
		adcs_result_t            inj_res;
		logic [`ADCS_IRQ_W-1:0]  status;
		logic [`ADCS_IRQ_W-1:0]  mask;
		logic [`ADCS_DATA_W-1:0] rdata;
		logic                    xfer;
	} adcs_state_t;

endpackage : adcs_pkg
`default_nettype wire

// ---- core/adcs_pin_sync.sv ----
// three-stage synchroniser for the digital channel pins
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"
module adcs_pin_sync
	import adcs_pkg::*;
#(
	parameter int W = `ADCS_NCHAN
) (
	// clock, reset, enable
	input  wire logic         i_mclk,
	input  wire logic         i_reset,
	input  wire logic         i_ce,
	// pins and settled value
	input  wire logic [W-1:0] i_pins,
	output var  logic [W-1:0] o_pins
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} adcs_sync_t;

	adcs_sync_t s_q;
	adcs_sync_t s_d;

	// a bit only moves once stages two and three agree, so a one-cycle glitch never reaches software
	always_comb begin
		s_d     = s_q;
		s_d.s1  = i_pins;
		s_d.s2  = s_q.s1;
		s_d.s3  = s_q.s2;
		s_d.out = (~(s_q.s2 ^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.out);
	end

	// state register
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			s_q <= '0;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	assign o_pins = s_q.out;

endmodule : adcs_pin_sync
`default_nettype wire

// ---- core/adcs_sequencer.sv ----
// conversion sequencer of a 16-input 10-bit converter, register port and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"
module adcs_sequencer
	import adcs_pkg::*;
#(
	parameter int BASE_DIV     = `ADCS_BASE_DIV,
	parameter int CONV_PERIODS = `ADCS_CONV_PERIODS
) (
	// clock, reset, enable
	input  wire logic                    i_mclk,
	input  wire logic                    i_reset,
	input  wire logic                    i_ce,
	// register port
	input  wire adcs_bus_t               i_bus,
	output var  logic [`ADCS_DATA_W-1:0] o_rdata,
	// system side
	output var  logic                    o_irq,
	output var  logic                    o_xfer_req,
	output var  logic                    o_busy,
	// analog core
	output var  logic [`ADCS_CHAN_W-1:0] o_ana_chan,
	output var  logic                    o_ana_sample,
	output var  logic                    o_ana_convert,
	input  wire logic [`ADCS_RES_W-1:0]  i_ana_result,
	// channel pins read digitally
	input  wire logic [`ADCS_NCHAN-1:0]  i_chan_pins
);

	adcs_state_t s;
	adcs_state_t n;
	logic [`ADCS_NCHAN-1:0] pins;

	adcs_pin_sync #(
		.W(`ADCS_NCHAN)
	) u_pins (
		.i_mclk (i_mclk),
		.i_reset(i_reset),
		.i_ce   (i_ce),
		.i_pins (i_chan_pins),
		.o_pins (pins)
	);

	// conversion clock length; reserved code falls back to the shortest
	function automatic logic [15:0] tcc_len(input logic [1:0] code);
		logic [15:0] base;
		case (code)
			`ADCS_TCC_CODE_24: base = `ADCS_TCC_24;
			`ADCS_TCC_CODE_48: base = `ADCS_TCC_48;
			`ADCS_TCC_CODE_96: base = `ADCS_TCC_96;
			default:           base = `ADCS_TCC_24;
		endcase
		tcc_len = 16'(base * 16'(BASE_DIV));
	endfunction : tcc_len

	// sample length is the conversion clock shifted by the select
	function automatic logic [15:0] sample_len(input adcs_ctrl_t c);
		sample_len = tcc_len(c.ctc) << c.stc;
	endfunction : sample_len

	// length of the conversion phase
	function automatic logic [15:0] conv_len(input adcs_ctrl_t c);
		conv_len = 16'(tcc_len(c.ctc) * 16'(CONV_PERIODS));
	endfunction : conv_len

	// next channel and run flag after a stored result
	function automatic logic [4:0] step_channel(input adcs_ctrl_t c, input logic [3:0] cur);
		logic scan;
		logic cont;
		scan = c.mode[`ADCS_MODE_SCAN];
		cont = c.mode[`ADCS_MODE_CONT];
		if (scan && cur != '0) begin
			step_channel = {1'b1, cur - 4'h1};
		end else begin
			step_channel = {cont, c.chan};
		end
	endfunction : step_channel

	// next-state logic
	always_comb begin
		adcs_ctrl_t             wc;
		adcs_ctrl_t             rc;
		adcs_inj_t              wi;
		adcs_inj_t              ri;
		adcs_result_t           res_new;
		logic [`ADCS_IRQ_W-1:0] ev;
		logic [`ADCS_IRQ_W-1:0] clr;
		logic [4:0]             adv;
		logic                   rd_res;
		logic                   cont;
		wc      = adcs_ctrl_t'(i_bus.wdata);
		rc      = s.ctrl;
		wi      = adcs_inj_t'(i_bus.wdata);
		ri      = '0;
		res_new = '0;
		ev      = '0;
		clr     = '0;
		adv     = '0;
		rd_res  = i_bus.rd && (i_bus.addr == `ADCS_ADDR_RESULT);
		cont    = s.ctrl.mode[`ADCS_MODE_CONT];
		n       = s;
		n.xfer  = 1'b0;
		n.rdata = '0;

		// reads, with their side effects on the result flags
		if (i_bus.rd) begin
			case (i_bus.addr)
				`ADCS_ADDR_CTRL: begin
					rc.start = s.busy;
					n.rdata  = rc;
				end
				`ADCS_ADDR_RESULT: begin
					n.rdata    = s.res;
					n.res_full = 1'b0;
				end
				`ADCS_ADDR_INJ_CTRL: begin
					ri.req  = s.inj_pend;
					ri.chan = s.inj_chan;
					n.rdata = ri;
				end
				`ADCS_ADDR_INJ_RESULT: n.rdata = s.inj_res;
				`ADCS_ADDR_IRQ_STATUS: n.rdata = 16'(s.status);
				`ADCS_ADDR_IRQ_MASK:   n.rdata = 16'(s.mask);
				`ADCS_ADDR_PINS:       n.rdata = pins;
				`ADCS_ADDR_FLAGS:      n.rdata = 16'({s.inj_active, s.tmp_full, s.res_full});
				default:               n.rdata = '0;
			endcase
		end

		// parked result moves up as soon as the old one is read
		if (rd_res && s.tmp_full) begin
			n.res                 = s.tmp;
			n.res_full            = 1'b1;
			n.tmp_full            = 1'b0;
			n.xfer                = 1'b1;
			ev[`ADCS_IRQ_DONE]    = 1'b1;
		end

		// conversion sequencing
		case (s.st)
			ST_IDLE: begin
				if (s.busy) begin
					// injection slips in between two continuous conversions
					if (s.inj_pend && cont) begin
						n.inj_active = 1'b1;
						n.inj_pend   = 1'b0;
						n.mux_chan   = s.inj_chan;
						n.cnt        = sample_len(s.ctrl) - 16'h0001;
						n.st         = ST_SAMPLE;
					// suspend holds off while the result is unread
					end else if (!(s.ctrl.ovr_susp && n.res_full)) begin
						n.mux_chan = s.cur_chan;
						n.cnt      = sample_len(s.ctrl) - 16'h0001;
						n.st       = ST_SAMPLE;
					end
				end
			end
			ST_SAMPLE: begin
				if (s.cnt == '0) begin
					n.cnt = conv_len(s.ctrl) - 16'h0001;
					n.st  = ST_CONVERT;
				end else begin
					n.cnt = s.cnt - 16'h0001;
				end
			end
			ST_CONVERT: begin
				if (s.cnt != '0) begin
					n.cnt = s.cnt - 16'h0001;
				end else begin
					// capture the 10-bit value with its channel
					res_new.val  = i_ana_result;
					res_new.chan = s.mux_chan;
					n.st         = ST_IDLE;
					if (s.inj_active) begin
						// only the injection flag drops, the mode stays put
						n.inj_res          = res_new;
						n.inj_active       = 1'b0;
						ev[`ADCS_IRQ_INJ]  = 1'b1;
					end else if (s.ctrl.wfr && cont && n.res_full) begin
						// park the new result and pause
						n.tmp      = res_new;
						n.tmp_full = 1'b1;
						n.st       = ST_HOLD;
					end else begin
						// overrun when the old result was never read
						if (n.res_full && !s.ctrl.ovr_susp) begin
							ev[`ADCS_IRQ_OVR] = 1'b1;
						end
						n.res      = res_new;
						n.res_full = 1'b1;
						n.xfer     = 1'b1;
						ev[`ADCS_IRQ_DONE] = 1'b1;
						adv        = step_channel(s.ctrl, s.cur_chan);
						n.busy     = s.busy && adv[4];
						n.cur_chan = adv[3:0];
					end
				end
			end
			ST_HOLD: begin
				if (!n.tmp_full) begin
					adv        = step_channel(s.ctrl, s.cur_chan);
					n.busy     = s.busy && adv[4];
					n.cur_chan = adv[3:0];
					n.st       = ST_IDLE;
				end
			end
			default: n.st = ST_IDLE;
		endcase

		// writes; a start while running only changes the configuration
		if (i_bus.wr) begin
			case (i_bus.addr)
				`ADCS_ADDR_CTRL: begin
					n.ctrl        = wc;
					n.ctrl.start  = 1'b0;
					n.ctrl.rsv_hi = '0;
					n.ctrl.rsv_lo = 1'b0;
					if (!wc.start) begin
						n.busy = 1'b0;
					end else if (!s.busy) begin
						n.busy     = 1'b1;
						n.cur_chan = wc.chan;
					end
				end
				`ADCS_ADDR_INJ_CTRL: begin
					n.inj_chan = wi.chan;
					if (wi.req) begin
						n.inj_pend = 1'b1;
					end
				end
				`ADCS_ADDR_IRQ_STATUS: clr = i_bus.wdata[`ADCS_IRQ_W-1:0];
				`ADCS_ADDR_IRQ_MASK:   n.mask = i_bus.wdata[`ADCS_IRQ_W-1:0];
				default: ;
			endcase
		end

		// a new event beats a write-one-to-clear in the same cycle
		n.status = (s.status & ~clr) | ev;
	end

	// state register; clock enable freezes everything
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			s      <= '0;
			s.st   <= ST_IDLE;
			s.ctrl <= `ADCS_CTRL_RST;
			s.cnt  <= `ADCS_CNT_RST;
		end else if (i_ce) begin
			s <= n;
		end
	end

	// outputs, all decoded from registered state
	assign o_rdata       = s.rdata;
	assign o_irq         = |(s.status & s.mask);
	assign o_xfer_req    = s.xfer;
	assign o_busy        = s.busy;
	assign o_ana_chan    = s.mux_chan;
	assign o_ana_sample  = (s.st == ST_SAMPLE);
	assign o_ana_convert = (s.st == ST_CONVERT);

	// helper terms for the checks below
	logic conv_end;
	logic rd_res_w;
	logic wr_any;
	logic norm_end;
	assign conv_end = (s.st == ST_CONVERT) && (s.cnt == '0);
	assign rd_res_w = i_bus.rd && (i_bus.addr == `ADCS_ADDR_RESULT);
	assign wr_any   = i_bus.wr;
	assign norm_end = conv_end && !s.inj_active
		&& !(s.ctrl.wfr && s.ctrl.mode[`ADCS_MODE_CONT] && s.res_full && !rd_res_w);

	default clocking adcs_cb @(posedge i_mclk iff i_ce);
	endclocking
	default disable iff (i_reset);

	chan_held_a: assert property (
		(s.st == ST_SAMPLE) |=> (s.st inside {ST_SAMPLE, ST_CONVERT}) && $stable(o_ana_chan))
		else $error("channel changed during a conversion");

	overrun_flag_a: assert property (
		norm_end && s.res_full && !rd_res_w && !s.ctrl.ovr_susp |=> s.status[`ADCS_IRQ_OVR])
		else $error("overrun not flagged");

	suspend_wait_a: assert property (
		(s.st == ST_IDLE) && s.busy && s.ctrl.ovr_susp && s.res_full && !rd_res_w && !s.inj_pend
		|=> (s.st == ST_IDLE))
		else $error("conversion started over an unread result");

	pin_read_a: assert property (
		i_bus.rd && (i_bus.addr == `ADCS_ADDR_PINS) |=> (o_rdata == $past(pins)))
		else $error("pin read mismatch");

	single_stop_a: assert property (
		norm_end && (s.ctrl.mode == `ADCS_MODE_SGL_ONCE) && !wr_any |=> !o_busy ##1 (s.st == ST_IDLE))
		else $error("single conversion did not stop");

	cont_run_a: assert property (
		norm_end && s.ctrl.mode[`ADCS_MODE_CONT] && s.busy && !wr_any |=> o_busy)
		else $error("continuous mode stopped");

	scan_step_a: assert property (
		norm_end && s.ctrl.mode[`ADCS_MODE_SCAN] && (s.cur_chan != '0) && !wr_any
		|=> (s.cur_chan == $past(s.cur_chan) - 4'h1))
		else $error("scan did not step down");

	scan_wrap_a: assert property (
		norm_end && s.ctrl.mode[`ADCS_MODE_SCAN] && s.ctrl.mode[`ADCS_MODE_CONT] && (s.cur_chan == '0) && s.busy && !wr_any
		|=> o_busy && (s.cur_chan == s.ctrl.chan))
		else $error("continuous scan did not wrap");

	xfer_pulse_a: assert property (
		norm_end |=> o_xfer_req && (s.res.val == $past(i_ana_result)) ##1 !o_xfer_req || $past(rd_res_w))
		else $error("transfer request missing");

	wait_hold_a: assert property (
		(s.st == ST_HOLD) && !rd_res_w |=> (s.st == ST_HOLD) && s.tmp_full)
		else $error("hold released without a read");

	inj_result_a: assert property (
		conv_end && s.inj_active |=> (s.inj_res.val == $past(i_ana_result)) && s.status[`ADCS_IRQ_INJ])
		else $error("injection result lost");

	inj_resume_a: assert property (
		conv_end && s.inj_active && !wr_any |=> $stable(s.ctrl) && $stable(s.cur_chan) && $stable(o_busy))
		else $error("mode changed by injection");

	conv_len_a: assert property (
		(s.st == ST_SAMPLE) && (s.cnt == '0) |=> (s.cnt == $past(conv_len(s.ctrl)) - 16'h0001))
		else $error("conversion length wrong");

	sample_len_a: assert property (
		(s.st == ST_IDLE) ##1 (s.st == ST_SAMPLE) |-> (s.cnt == $past(sample_len(s.ctrl)) - 16'h0001))
		else $error("sample length wrong");

	done_irq_a: assert property (
		norm_end |=> s.status[`ADCS_IRQ_DONE])
		else $error("completion flag not set");

endmodule : adcs_sequencer
`default_nettype wire

// ---- verification/test_adcs_sequencer.sv ----
// self-checking bench of the conversion sequencer with a queue-based result model
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"
module test_adcs_sequencer
	import adcs_pkg::*;
;
	// one convert clock per conversion keeps every run short
	localparam int CP = 1;

	logic                    i_mclk;
	logic                    i_reset;
	logic                    i_ce;
	adcs_bus_t               i_bus;
	logic [`ADCS_DATA_W-1:0] o_rdata;
	logic                    o_irq;
	logic                    o_xfer_req;
	logic                    o_busy;
	logic [`ADCS_CHAN_W-1:0] o_ana_chan;
	logic                    o_ana_sample;
	logic                    o_ana_convert;
	logic [`ADCS_RES_W-1:0]  i_ana_result = 10'h000;
	logic [`ADCS_NCHAN-1:0]  i_chan_pins;
	int                      n_errors;
	int                      num_checks;
	int                      n_xfer = 0;
	int                      n_samp = 0;
	int                      n_conv = 0;
	logic [31:0]             rng = 32'hE5A18244;
	logic [31:0]             prng;
	logic [9:0]              conv_val = 10'h000;
	logic [3:0]              conv_ch = 4'h0;
	logic                    conv_prev = 1'b0;
	logic [9:0]              vals[$];
	logic [15:0]             rd_word;
	int                      tccs[4] = '{24, 48, 96, 24};
	logic [1:0]              ctcs[4] = '{2'h0, 2'h3, 2'h2, 2'h0};
	logic [3:0]              chs[4]  = '{4'hF, 4'h0, 4'h6, 4'hA};

	adcs_sequencer #(.BASE_DIV(1), .CONV_PERIODS(CP)) adcs_sequencer_inst (
		.i_mclk        (i_mclk),
		.i_reset       (i_reset),
		.i_ce          (i_ce),
		.i_bus         (i_bus),
		.o_rdata       (o_rdata),
		.o_irq         (o_irq),
		.o_xfer_req    (o_xfer_req),
		.o_busy        (o_busy),
		.o_ana_chan    (o_ana_chan),
		.o_ana_sample  (o_ana_sample),
		.o_ana_convert (o_ana_convert),
		.i_ana_result  (i_ana_result),
		.i_chan_pins   (i_chan_pins)
	);

	// free-running clock
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs

	// control word; start bit always set
	function automatic logic [15:0] cw(input logic [1:0] ctc, input logic [1:0] stc, input logic susp,
		input logic wfr, input logic [1:0] mode, input logic [3:0] ch);
		return {ctc, stc, 2'h0, susp, wfr, 1'b1, 1'b0, mode, ch};
	endfunction : cw

	function automatic logic [15:0] rw(input logic [3:0] ch, input logic [9:0] v);
		return {ch, 2'h0, v};
	endfunction : rw

	// analog core stand-in: new value only while sampling, so it is stable through convert
	always @(posedge i_mclk) begin
		if (o_xfer_req === 1'b1) n_xfer <= n_xfer + 1;
		if (o_ana_sample === 1'b1) begin
			n_samp       <= n_samp + 1;
			rng          <= xs(rng);
			i_ana_result <= rng[9:0];
		end
		if (o_ana_convert === 1'b1) begin
			n_conv   <= n_conv + 1;
			conv_val <= i_ana_result;
			conv_ch  <= o_ana_chan;
		end
		if (conv_prev && o_ana_convert !== 1'b1) vals.push_back(conv_val);
		conv_prev <= (o_ana_convert === 1'b1);
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_mclk);
		i_bus <= '0;
		#1;
	endtask : bus_wr

	// read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [3:0] a);
		@(posedge i_mclk);
		i_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_mclk);
		i_bus <= '0;
		#1 rd_word = o_rdata;
	endtask : bus_rd

	// bounded wait on result pulses or finished conversions
	task automatic wait_for(input bit on_vals, input int n);
		int k;
		k = 0;
		while ((on_vals ? vals.size() : n_xfer) < n && k < 4000) begin
			@(posedge i_mclk);
			#1 k++;
		end
		if (k >= 4000) begin
			n_errors++;
			$display("ERROR %0t: result never came", $time);
		end
	endtask : wait_for

	// stop, drain result and parked words, clear status
	task automatic quiesce;
		int k;
		bus_wr(`ADCS_ADDR_CTRL, 16'h0000);
		k = 0;
		// a stop lets the running conversion finish and store, so wait for the converter as well
		while ((o_busy | o_ana_sample | o_ana_convert) !== 1'b0 && k < 4000) begin
			@(posedge i_mclk);
			#1 k++;
		end
		if (k >= 4000) begin
			n_errors++;
			$display("ERROR %0t: sequencer never went idle", $time);
		end
		bus_rd(`ADCS_ADDR_RESULT);
		bus_rd(`ADCS_ADDR_RESULT);
		bus_wr(`ADCS_ADDR_IRQ_STATUS, 16'h0007);
		vals.delete();
	endtask : quiesce

	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	// watchdog well beyond the few thousand cycles the tests need
	initial begin
		#(60000 * 5);
		n_errors++;
		$display("ERROR %0t: watchdog expired", $time);
		end_sim();
	end

	initial begin
		int base;
		int s0;
		int c0;
		i_reset = 1'b1; i_ce = 1'b1; i_bus = '0; i_chan_pins = 16'h0000;
		prng = 32'hE5A18244;
		n_errors = 0; num_checks = 0;
		repeat (5) @(posedge i_mclk);
		i_reset <= 1'b0;
		// idle control, closed mask, unmapped place
		bus_rd(`ADCS_ADDR_CTRL);    chk(rd_word, 16'h0000);
		bus_rd(`ADCS_ADDR_IRQ_MASK); chk(rd_word, 16'h0000);
		bus_rd(4'h8);               chk(rd_word, 16'h0000);
		// digital pins through the synchroniser
		repeat (2) begin
			@(posedge i_mclk);
			prng = xs(prng);
			i_chan_pins <= prng[15:0];
			repeat (5) @(posedge i_mclk);
			bus_rd(`ADCS_ADDR_PINS); chk(rd_word, prng[15:0]);
		end
		// single once with clock codes 0, 3 and 2 and every sample length
		for (int i = 0; i < 4; i++) begin
			vals.delete(); base = n_xfer; s0 = n_samp; c0 = n_conv;
			bus_wr(`ADCS_ADDR_CTRL, cw(ctcs[i], 2'(i), 1'b0, 1'b0, `ADCS_MODE_SGL_ONCE, chs[i]));
			wait_for(1'b0, base + 1);
			chk(16'(n_samp - s0), 16'(tccs[i] << i));
			chk(16'(n_conv - c0), 16'(tccs[i] * CP));
			chk({15'h0000, o_busy}, 16'h0000);
			chk(16'(conv_ch), 16'(chs[i]));
			bus_rd(`ADCS_ADDR_RESULT); chk(rd_word, rw(chs[i], vals[0]));
			repeat (60) @(posedge i_mclk);
			chk(16'(n_xfer - base), 16'h0001);
		end
		// sticky done bit, masked then unmasked, then cleared
		chk({15'h0000, o_irq}, 16'h0000);
		bus_rd(`ADCS_ADDR_IRQ_STATUS); chk(rd_word, 16'h0001);
		bus_wr(`ADCS_ADDR_IRQ_MASK, 16'h0007); chk({15'h0000, o_irq}, 16'h0001);
		bus_wr(`ADCS_ADDR_IRQ_STATUS, 16'h0001); chk({15'h0000, o_irq}, 16'h0000);
		// continuous, no suspend: second result lands on unread first
		quiesce(); base = n_xfer;
		bus_wr(`ADCS_ADDR_CTRL, cw(2'h0, 2'h0, 1'b0, 1'b0, 2'h1, 4'h7));
		wait_for(1'b0, base + 2);
		chk({15'h0000, o_irq}, 16'h0001);
		bus_rd(`ADCS_ADDR_IRQ_STATUS); chk(rd_word & 16'h0002, 16'h0002);
		bus_rd(`ADCS_ADDR_RESULT); chk(rd_word, rw(4'h7, vals[1]));
		// continuous with suspend, plus an injected channel
		quiesce(); base = n_xfer;
		bus_wr(`ADCS_ADDR_CTRL, cw(2'h0, 2'h0, 1'b1, 1'b0, 2'h1, 4'h5));
		wait_for(1'b0, base + 1);
		s0 = n_samp;
		repeat (100) @(posedge i_mclk);
		chk(16'(n_samp - s0), 16'h0000);
		bus_wr(`ADCS_ADDR_INJ_CTRL, 16'h0019);
		wait_for(1'b1, 2);
		repeat (3) @(posedge i_mclk);
		bus_rd(`ADCS_ADDR_INJ_RESULT); chk(rd_word, rw(4'h9, vals[1]));
		chk(16'(n_xfer - base), 16'h0001);
		bus_rd(`ADCS_ADDR_IRQ_STATUS); chk(rd_word & 16'h0004, 16'h0004);
		bus_rd(`ADCS_ADDR_RESULT); chk(rd_word, rw(4'h5, vals[0]));
		wait_for(1'b0, base + 2);
		bus_rd(`ADCS_ADDR_RESULT); chk(rd_word, rw(4'h5, vals[2]));
		bus_rd(`ADCS_ADDR_CTRL); chk(rd_word, cw(2'h0, 2'h0, 1'b1, 1'b0, 2'h1, 4'h5));
		// scan once from channel 3 down to 0
		quiesce(); base = n_xfer;
		bus_wr(`ADCS_ADDR_CTRL, cw(2'h0, 2'h0, 1'b0, 1'b0, 2'h2, 4'h3));
		for (int k = 0; k < 4; k++) begin
			wait_for(1'b0, base + k + 1);
			bus_rd(`ADCS_ADDR_RESULT); chk(rd_word, rw(4'(3 - k), vals[k]));
		end
		repeat (100) @(posedge i_mclk);
		chk(16'(n_xfer - base), 16'h0004);
		chk({15'h0000, o_busy}, 16'h0000);
		// scan continuous with wait-for-read: park, hold, release by reads
		quiesce(); base = n_xfer;
		bus_wr(`ADCS_ADDR_CTRL, cw(2'h0, 2'h0, 1'b0, 1'b1, 2'h3, 4'h1));
		wait_for(1'b1, 2);
		s0 = n_samp;
		repeat (100) @(posedge i_mclk);
		chk(16'(n_samp - s0), 16'h0000);
		bus_rd(`ADCS_ADDR_RESULT); chk(rd_word, rw(4'h1, vals[0]));
		bus_rd(`ADCS_ADDR_RESULT); chk(rd_word, rw(4'h0, vals[1]));
		wait_for(1'b0, base + 3);
		bus_rd(`ADCS_ADDR_RESULT); chk(rd_word, rw(4'h1, vals[2]));
		bus_rd(`ADCS_ADDR_IRQ_STATUS); chk(rd_word & 16'h0002, 16'h0000);
		quiesce();
		end_sim();
	end
endmodule : test_adcs_sequencer
`default_nettype wire
